// File: ipsb_bridge.sv
// Purpose: Bridge between a four-wire serial slave port and a pulse link.
// Assumes: clk 20 MHz; link_clk is the receive sampling clock of port A.
// Notes:   Port B always masters the pulse link; port A role set by a pin.
//
// Functional notes
// - Transmitter drives only plus, zero or minus, zero when both off.
// - Plus symbol: positive half then equal negative half, then zero.
// - Minus symbol: negative half then equal positive half, then zero.
// - Half pulse is 150 ns long, 50 ns short.
// - Four-wire mode detects select fall, select rise, clock rise with data.
// - Port B sends long plus on select rise, long minus on fall.
// - Port B sends short plus for data 1, short minus for 0.
// - Pulse slave rebuilds select, data then clock pulse from symbols.
// - Reading a 0 bit answers with short minus; otherwise no return.
// - Port A never sends long select symbols.
// - Slave port only sends short minus symbols, never plus.
// - Master takes missing return pulse as read bit 1.
// - Port B always pulse master; port A slave of either form.
// - Mode pin low selects four-wire port A, high selects pulse.
// - After command and check code, devices shift out read data.
// - Bottom device outputs own data first, then higher devices.
// - Four-wire port is clock polarity 1 phase 1, up to 1 Mbps.
// - Bytes MSB first; select held low for the whole sequence.
// - Write data latched on select rising edge.

`timescale 1ns/1ps

module ipsb_bridge (
    input  wire logic clk,
    input  wire logic reset,
    input  wire logic link_clk,
    input  wire logic port_mode_select,
    input  wire logic spi_sck,
    input  wire logic port_select_low,
    input  wire logic spi_sdi,
    output logic      spi_sdo_out,
    output logic      spi_sdo_oe,
    input  wire logic a_rx_pos,
    input  wire logic a_rx_neg,
    output logic      a_tx_pos,
    output logic      a_tx_neg,
    output logic      b_tx_pos,
    output logic      b_tx_neg,
    input  wire logic b_rx_pos,
    input  wire logic b_rx_neg,
    output logic      core_csn,
    output logic      core_sdi,
    output logic      core_sck_pulse,
    output logic      core_write_latch,
    input  wire logic core_read_mode,
    input  wire logic core_own_active,
    input  wire logic core_read_bit
);
    // ======================================================================
    // Link domain: port A pulse receiver
    logic                     l_rst_s1;
    logic                     l_rst;
    logic                     l_pos_s1;
    logic                     l_pos;
    logic                     l_neg_s1;
    logic                     l_neg;
    ipsb_pkg::ipsb_rx_state_t rx_state;
    logic                     rx_sign;
    logic                     rx_long;
    logic [4:0]               rx_count;
    logic                     first_lvl;
    logic                     l_evt_tog;
    logic                     l_evt_sign;
    logic                     l_evt_long;

    always_ff @(posedge link_clk) begin
        l_rst_s1 <= reset;
        l_rst    <= l_rst_s1;
        l_pos_s1 <= a_rx_pos;
        l_pos    <= l_pos_s1;
        l_neg_s1 <= a_rx_neg;
        l_neg    <= l_neg_s1;
    end

    assign first_lvl = rx_sign ? l_pos : l_neg;

    always_ff @(posedge link_clk) begin
        if (l_rst) begin
            rx_state <= ipsb_pkg::IPSB_RX_IDLE;
            rx_sign  <= 1'b0;
            rx_long  <= 1'b0;
            rx_count <= 5'h00;
        end else begin
            case (rx_state)
                ipsb_pkg::IPSB_RX_IDLE: begin
                    if (l_pos != l_neg) begin
                        rx_sign  <= l_pos;
                        rx_count <= 5'h01;
                        rx_state <= ipsb_pkg::IPSB_RX_FIRST;
                    end
                end
                ipsb_pkg::IPSB_RX_FIRST: begin
                    if (first_lvl) begin
                        if (rx_count != ipsb_pkg::RX_COUNT_MAX) begin
                            rx_count <= rx_count + 5'h01;
                        end
                    end else begin
                        rx_long  <= (rx_count >= ipsb_pkg::CLASS_THRESH_LC);
                        rx_state <= ipsb_pkg::IPSB_RX_SECOND;
                    end
                end
                ipsb_pkg::IPSB_RX_SECOND: begin
                    if (!l_pos && !l_neg) begin
                        rx_state <= ipsb_pkg::IPSB_RX_IDLE;
                    end
                end
                default: rx_state <= ipsb_pkg::IPSB_RX_IDLE;
            endcase
        end
    end

    // Data words stay still until the next symbol ends, long after the toggle
    always_ff @(posedge link_clk) begin
        if (l_rst) begin
            l_evt_tog  <= 1'b0;
            l_evt_sign <= 1'b0;
            l_evt_long <= 1'b0;
        end else if (rx_state == ipsb_pkg::IPSB_RX_SECOND && !l_pos && !l_neg) begin
            l_evt_tog  <= !l_evt_tog;
            l_evt_sign <= rx_sign;
            l_evt_long <= rx_long;
        end
    end

    // ======================================================================
    // Pin synchronisers on clk
    logic mode_s1;
    logic mode_pulse;
    logic sck_s1;
    logic sck_s2;
    logic sck_s3;
    logic cs_s1;
    logic cs_s2;
    logic cs_s3;
    logic sdi_s1;
    logic sdi_s2;
    logic bneg_s1;
    logic bneg_s2;
    logic bneg_s3;
    logic tog_s1;
    logic tog_s2;
    logic tog_s3;

    always_ff @(posedge clk) begin
        mode_s1    <= port_mode_select;
        mode_pulse <= mode_s1;
        sck_s1     <= spi_sck;
        sck_s2     <= sck_s1;
        sck_s3     <= sck_s2;
        cs_s1      <= port_select_low;
        cs_s2      <= cs_s1;
        cs_s3      <= cs_s2;
        sdi_s1     <= spi_sdi;
        sdi_s2     <= sdi_s1;
        bneg_s1    <= b_rx_neg;
        bneg_s2    <= bneg_s1;
        bneg_s3    <= bneg_s2;
        tog_s1     <= l_evt_tog;
        tog_s2     <= tog_s1;
        tog_s3     <= tog_s2;
    end

    // ======================================================================
    // Event decode
    logic sck_rise;
    logic sck_fall;
    logic cs_rise;
    logic cs_fall;
    logic rx_evt;
    logic b_neg_rise;
    logic ev_valid;
    logic ev_sign;
    logic ev_long;

    // Rising clock samples data: polarity 1, phase 1
    assign sck_rise   = !mode_pulse && sck_s2 && !sck_s3 && !cs_s2;
    assign sck_fall   = !mode_pulse && !sck_s2 && sck_s3;
    assign cs_rise    = !mode_pulse && cs_s2 && !cs_s3;
    assign cs_fall    = !mode_pulse && !cs_s2 && cs_s3;
    assign rx_evt     = mode_pulse && (tog_s2 != tog_s3);
    assign b_neg_rise = bneg_s2 && !bneg_s3;

    always_comb begin
        ev_valid = 1'b0;
        ev_sign  = 1'b0;
        ev_long  = 1'b0;
        if (rx_evt) begin
            ev_valid = 1'b1;
            ev_sign  = l_evt_sign;
            ev_long  = l_evt_long;
        end else if (cs_rise || cs_fall) begin
            ev_valid = 1'b1;
            ev_sign  = cs_rise;
            ev_long  = 1'b1;
        end else if (sck_rise) begin
            ev_valid = 1'b1;
            ev_sign  = sdi_s2;
            ev_long  = 1'b0;
        end
    end

    // ======================================================================
    // Internal serial rebuild
    logic sck_pend;

    // Select stays low across command and data; the core frames on it
    always_ff @(posedge clk) begin
        if (reset) begin
            core_csn <= ipsb_pkg::CSN_RESET;
        end else if (ev_valid && ev_long) begin
            core_csn <= ev_sign;
        end
    end

    // Data first, clock one cycle later, so the core sees settled data
    always_ff @(posedge clk) begin
        if (reset) begin
            core_sdi       <= 1'b0;
            sck_pend       <= 1'b0;
            core_sck_pulse <= 1'b0;
        end else begin
            if (ev_valid && !ev_long) begin
                core_sdi <= ev_sign;
            end
            sck_pend       <= ev_valid && !ev_long;
            core_sck_pulse <= sck_pend;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            core_write_latch <= 1'b0;
        end else begin
            core_write_latch <= ev_valid && ev_long && ev_sign;
        end
    end

    // ======================================================================
    // Port B master and return detection
    logic b_busy;
    logic b_busy_q;
    logic b_short;
    logic b_done;
    logic [5:0] win_cnt;
    logic ret_bit;
    logic read_bit;

    // Port B is always the pulse master; each event that finds it idle is passed upward
    ipsb_pulse_tx u_tx_b (
        .clk      (clk),
        .reset    (reset),
        .start    (ev_valid),
        .sign     (ev_sign),
        .long_sym (ev_long),
        .out_pos  (b_tx_pos),
        .out_neg  (b_tx_neg),
        .busy     (b_busy)
    );

    assign b_done = b_busy_q && !b_busy;

    always_ff @(posedge clk) begin
        if (reset) begin
            b_busy_q <= 1'b0;
            b_short  <= 1'b0;
        end else begin
            b_busy_q <= b_busy;
            if (ev_valid && !b_busy) begin
                b_short <= !ev_long;
            end
        end
    end

    // Silence in the window reads as 1; a minus return reads as 0
    always_ff @(posedge clk) begin
        if (reset) begin
            win_cnt <= 6'h00;
            ret_bit <= ipsb_pkg::RET_BIT_RESET;
        end else if (b_done && b_short) begin
            win_cnt <= ipsb_pkg::RET_WINDOW_CYC;
            ret_bit <= 1'b1;
        end else if (win_cnt != 6'h00) begin
            win_cnt <= win_cnt - 6'h01;
            if (b_neg_rise) begin
                ret_bit <= 1'b0;
            end
        end
    end

    // Own data first, then what came back from the devices above
    assign read_bit = core_own_active ? core_read_bit : ret_bit;

    // ======================================================================
    // Port A return pulses and four-wire data out
    logic a_ret_req;
    logic a_busy;
    logic sdo_bit;

    always_ff @(posedge clk) begin
        if (reset) begin
            a_ret_req <= 1'b0;
        end else begin
            a_ret_req <= mode_pulse && ev_valid && !ev_long
                      && core_read_mode && !read_bit;
        end
    end

    // Only short minus is ever asked for, so slaves can share a cable
    ipsb_pulse_tx u_tx_a (
        .clk      (clk),
        .reset    (reset),
        .start    (a_ret_req),
        .sign     (1'b0),
        .long_sym (1'b0),
        .out_pos  (a_tx_pos),
        .out_neg  (a_tx_neg),
        .busy     (a_busy)
    );

    // Open drain: only ever pulls low
    assign spi_sdo_out = 1'b0;

    always_ff @(posedge clk) begin
        if (reset) begin
            sdo_bit <= 1'b1;
        end else if (cs_fall) begin
            sdo_bit <= 1'b1;
        end else if (sck_fall) begin
            sdo_bit <= read_bit;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            spi_sdo_oe <= 1'b0;
        end else begin
            spi_sdo_oe <= !mode_pulse && !core_csn && !sdo_bit;
        end
    end

    // ======================================================================
    // Checks
    a_csn_from_long: assert property (
        @(posedge clk) disable iff (reset)
        ev_valid && ev_long |=> core_csn == $past(ev_sign))
        else $error("rebuilt select does not follow long symbol");
    a_sdi_then_sck: assert property (
        @(posedge clk) disable iff (reset)
        ev_valid && !ev_long |=> (core_sdi == $past(ev_sign) && !core_sck_pulse)
        ##1 core_sck_pulse)
        else $error("data and clock pulse order wrong");
    a_spi_cs_event: assert property (
        @(posedge clk) disable iff (reset)
        cs_fall |-> ev_valid && ev_long && !ev_sign)
        else $error("select fall not sent as long minus");
    a_spi_data_event: assert property (
        @(posedge clk) disable iff (reset)
        sck_rise && !cs_rise && !cs_fall && !rx_evt |-> ev_valid && !ev_long && ev_sign == sdi_s2)
        else $error("clock rise not sent as short symbol");
    a_return_zero: assert property (
        @(posedge clk) disable iff (reset)
        mode_pulse && ev_valid && !ev_long && core_read_mode && !read_bit && !a_busy
        |-> ##2 a_tx_neg ##1 a_tx_pos)
        else $error("zero bit not answered with short minus");
    a_return_none_one: assert property (
        @(posedge clk) disable iff (reset)
        ev_valid && read_bit |=> !a_ret_req)
        else $error("return pulse sent for a one bit");
    a_a_short_only: assert property (
        @(posedge clk) disable iff (reset)
        $rose(a_tx_neg) |=> !a_tx_neg)
        else $error("port A sent a long half pulse");
    a_a_no_plus: assert property (
        @(posedge clk) disable iff (reset)
        a_tx_pos |-> $past(a_tx_neg))
        else $error("port A began a plus symbol");
    a_ret_default_one: assert property (
        @(posedge clk) disable iff (reset)
        b_done && b_short |=> ret_bit && win_cnt == ipsb_pkg::RET_WINDOW_CYC)
        else $error("return window did not open with bit 1");
    a_ret_seen_zero: assert property (
        @(posedge clk) disable iff (reset)
        win_cnt != 6'h00 && b_neg_rise && !b_done |=> !ret_bit)
        else $error("return pulse not read as 0");
    a_sdo_mode_only: assert property (
        @(posedge clk) disable iff (reset)
        spi_sdo_oe |-> $past(!mode_pulse))
        else $error("data out driven in pulse mode");
    a_write_latch_edge: assert property (
        @(posedge clk) disable iff (reset)
        ev_valid && ev_long && ev_sign |=> core_write_latch ##1 !core_write_latch)
        else $error("write latch pulse missing");
    a_rx_class_long: assert property (
        @(posedge link_clk) disable iff (l_rst)
        rx_state == ipsb_pkg::IPSB_RX_FIRST && !first_lvl
        |=> rx_long == ($past(rx_count) >= ipsb_pkg::CLASS_THRESH_LC))
        else $error("symbol length classed wrong");

    c_long_plus_b: cover property (
        @(posedge clk) disable iff (reset) ev_valid && ev_long && ev_sign);
    c_return_on_a: cover property (
        @(posedge clk) disable iff (reset) a_ret_req);
    c_ret_zero_b: cover property (
        @(posedge clk) disable iff (reset) win_cnt != 6'h00 && b_neg_rise);
    c_sdo_low: cover property (
        @(posedge clk) disable iff (reset) spi_sdo_oe);
endmodule

// File: ipsb_bridge_tb_top.sv
// Purpose: Self-checking bench for the pulse bridge.
// Assumes: Inputs change on falling edges; link_clk free running.
// Notes:   Four-wire phase first, then a second reset into pulse mode.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin tests_run++; if ((e) !== (g)) begin err_total++; \
    $display("[ERR] %s exp %0h got %0h", nm, e, g); end end

// ==========================================================================
// Bench
module ipsb_bridge_tb_top;
    logic clk = 1'b0, link_clk = 1'b0, reset = 1'b1, mode = 1'b0;
    logic sck = 1'b1, sel_n = 1'b1, sdi = 1'b0, a_pos = 1'b0, a_neg = 1'b0;
    logic rd_mode = 1'b0, own = 1'b0, rd_bit = 1'b0, ret_zero = 1'b0;
    logic at_pos, at_neg, bt_pos, bt_neg, br_pos, br_neg, csn, c_sdi, c_sck, c_wl;
    logic sdo_out, sdo_oe;
    int   err_total = 0, tests_run = 0, an = 0, ap = 0, ap_first = 0, sck_n = 0, wl_n = 0;

    initial forever #25 clk = ~clk;
    // Odd offset keeps the link clock out of phase with clk
    initial begin
        #3;
        forever #7.5 link_clk = ~link_clk;
    end

    ipsb_bridge dut (.clk(clk), .reset(reset), .link_clk(link_clk),
        .port_mode_select(mode), .spi_sck(sck), .port_select_low(sel_n), .spi_sdi(sdi),
        .spi_sdo_out(sdo_out), .spi_sdo_oe(sdo_oe), .a_rx_pos(a_pos), .a_rx_neg(a_neg),
        .a_tx_pos(at_pos), .a_tx_neg(at_neg), .b_tx_pos(bt_pos), .b_tx_neg(bt_neg),
        .b_rx_pos(br_pos), .b_rx_neg(br_neg), .core_csn(csn), .core_sdi(c_sdi),
        .core_sck_pulse(c_sck), .core_write_latch(c_wl), .core_read_mode(rd_mode),
        .core_own_active(own), .core_read_bit(rd_bit));

    ipsb_far_model far (.clk(clk), .b_tx_pos(bt_pos), .b_tx_neg(bt_neg),
        .ret_zero(ret_zero), .ret_delay(4'h3), .b_rx_pos(br_pos), .b_rx_neg(br_neg));

    always @(negedge clk) begin
        `CHK("b_both", 1'b0, bt_pos & bt_neg)
        if (at_pos === 1'b1 && an == 0) ap_first++;
        an += (at_neg === 1'b1);
        ap += (at_pos === 1'b1);
        sck_n += (c_sck === 1'b1);
        wl_n += (c_wl === 1'b1);
    end

    task automatic end_sim();
        if (err_total == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic get_sym(input string nm, input logic s, input int h);
        int n1 = 0, n2 = 0, k = 0;
        while (!(bt_pos | bt_neg) && k < 60) begin
            @(negedge clk);
            k++;
        end
        if (k == 60) begin
            err_total++;
            $display("[ERR] %s exp symbol got none", nm);
            end_sim();
        end
        `CHK(nm, s, bt_pos)
        while (bt_pos === s && bt_neg === !s) begin
            @(negedge clk);
            n1++;
        end
        while (bt_neg === s && bt_pos === !s) begin
            @(negedge clk);
            n2++;
        end
        `CHK(nm, h, n1)
        `CHK(nm, h, n2)
        `CHK(nm, 1'b0, bt_pos | bt_neg)
    endtask

    task automatic t_four();
        own = 1'b1;
        sel_n = 1'b0;
        get_sym("sel_fall", 1'b0, 3);
        for (int b = 1; b >= 0; b--) begin
            repeat (20) @(negedge clk);
            sck = 1'b0;
            sdi = b[0];
            rd_bit = !b[0];
            repeat (20) @(negedge clk);
            `CHK("sdo_oe", b[0], sdo_oe)
            `CHK("sdo_out", 1'b0, sdo_out)
            sck = 1'b1;
            get_sym("data_bit", b[0], 1);
        end
        wl_n = 0;
        repeat (20) @(negedge clk);
        sel_n = 1'b1;
        get_sym("sel_rise", 1'b1, 3);
        `CHK("write_latch", 1, wl_n)
    endtask

    task automatic a_sym(input logic s, input int h);
        @(negedge link_clk);
        a_pos = s;
        a_neg = !s;
        repeat (h) @(negedge link_clk);
        a_pos = !s;
        a_neg = s;
        repeat (h) @(negedge link_clk);
        a_pos = 1'b0;
        a_neg = 1'b0;
        // Long gap lets the return window close before the next symbol
        repeat (120) @(negedge link_clk);
        @(negedge clk);
    endtask

    task automatic t_pulse();
        rd_mode = 1'b1;
        own = 1'b1;
        rd_bit = 1'b1;
        a_sym(1'b0, 10);
        `CHK("csn_low", 1'b0, csn)
        {an, ap, ap_first, sck_n} = '0;
        a_sym(1'b1, 3);
        `CHK("sdi_one", 1'b1, c_sdi)
        `CHK("sck_pulse", 1, sck_n)
        `CHK("no_ret_one", 0, an + ap)
        rd_bit = 1'b0;
        a_sym(1'b0, 3);
        `CHK("sdi_zero", 1'b0, c_sdi)
        `CHK("ret_neg", 1, an)
        `CHK("ret_pos", 1, ap)
        `CHK("ret_order", 0, ap_first)
        {an, ap, rd_mode} = '0;
        a_sym(1'b0, 3);
        `CHK("no_ret_idle", 0, an + ap)
        {rd_mode, own} = 2'h2;
        a_sym(1'b1, 3);
        `CHK("null_is_one", 0, an)
        ret_zero = 1'b1;
        a_sym(1'b1, 3);
        an = 0;
        a_sym(1'b1, 3);
        `CHK("fwd_zero", 1, an)
        {an, ap} = '0;
        a_sym(1'b1, 10);
        `CHK("csn_high", 1'b1, csn)
        `CHK("no_long_tx", 0, an + ap)
    endtask

    initial begin
        repeat (4) @(negedge clk);
        reset = 1'b0;
        repeat (6) @(negedge clk);
        t_four();
        reset = 1'b1;
        mode = 1'b1;
        repeat (4) @(negedge clk);
        reset = 1'b0;
        repeat (6) @(negedge clk);
        t_pulse();
        end_sim();
    end
endmodule

// File: ipsb_far_model.sv
// Purpose: Stacked neighbour on port B that answers short data symbols.
// Assumes: Symbol length counted in clk cycles; short symbol is two cycles.
// Notes:   Answers only when ret_zero is set, after ret_delay cycles.
`timescale 1ns/1ps

// ==========================================================================
// Return pulse model
module ipsb_far_model (
    input  wire logic       clk,
    input  wire logic       b_tx_pos,
    input  wire logic       b_tx_neg,
    input  wire logic       ret_zero,
    input  wire logic [3:0] ret_delay,
    output logic            b_rx_pos = 1'b0,
    output logic            b_rx_neg = 1'b0
);
    int len = 0;
    always @(posedge clk) begin
        if (b_tx_pos | b_tx_neg) begin
            len <= len + 1;
        end else begin
            len <= 0;
            // Long select symbols never get an answer
            if (len == 2 && ret_zero) begin
                fork
                    begin
                        repeat (ret_delay) @(posedge clk);
                        b_rx_neg <= 1'b1;
                        @(posedge clk);
                        b_rx_neg <= 1'b0;
                        b_rx_pos <= 1'b1;
                        @(posedge clk);
                        b_rx_pos <= 1'b0;
                    end
                join_none
            end
        end
    end
endmodule

// File: ipsb_pulse_tx.sv
// Purpose: Shared constants and the differential pulse symbol transmitter.
// Assumes: clk at 20 MHz; one symbol request at a time, taken only while idle.
// Notes:   Pos and neg are registered and never high together; busy is decoded from state.

// ==========================================================================
// Shared constants
package ipsb_pkg;
    localparam int CLK_PERIOD_NS   = 50;
    localparam int LINK_PERIOD_PS  = 15000;
    localparam int SHORT_HALF_NS   = 50;
    localparam int LONG_HALF_NS    = 150;
    localparam int CLASS_THRESH_NS = 100;
    localparam int RET_WINDOW_NS   = 1000;

    localparam int SHORT_HALF_RAW  = SHORT_HALF_NS / CLK_PERIOD_NS;
    localparam int LONG_HALF_RAW   = LONG_HALF_NS / CLK_PERIOD_NS;
    localparam int THRESH_RAW      = (CLASS_THRESH_NS * 1000) / LINK_PERIOD_PS;
    localparam int RET_WINDOW_RAW  = RET_WINDOW_NS / CLK_PERIOD_NS;

    localparam logic [3:0] SHORT_HALF_CYC  = 4'((SHORT_HALF_RAW < 1) ? 1 : SHORT_HALF_RAW);
    localparam logic [3:0] LONG_HALF_CYC   = 4'((LONG_HALF_RAW < 1) ? 1 : LONG_HALF_RAW);
    localparam logic [4:0] CLASS_THRESH_LC = 5'((THRESH_RAW < 1) ? 1 : THRESH_RAW);
    localparam logic [5:0] RET_WINDOW_CYC  = 6'((RET_WINDOW_RAW < 1) ? 1 : RET_WINDOW_RAW);
    localparam logic [4:0] RX_COUNT_MAX    = 5'h1F;
    localparam logic       CSN_RESET       = 1'b1;
    localparam logic       RET_BIT_RESET   = 1'b1;

    typedef enum logic [1:0] {
        IPSB_TX_IDLE   = 2'b00,
        IPSB_TX_FIRST  = 2'b01,
        IPSB_TX_SECOND = 2'b10
    } ipsb_tx_state_t;

    typedef enum logic [1:0] {
        IPSB_RX_IDLE   = 2'b00,
        IPSB_RX_FIRST  = 2'b01,
        IPSB_RX_SECOND = 2'b10
    } ipsb_rx_state_t;
endpackage

`timescale 1ns/1ps

// ==========================================================================
// Symbol transmitter
module ipsb_pulse_tx (
    input  wire logic clk,
    input  wire logic reset,
    input  wire logic start,
    input  wire logic sign,
    input  wire logic long_sym,
    output logic      out_pos,
    output logic      out_neg,
    output logic      busy
);
    ipsb_pkg::ipsb_tx_state_t state;
    ipsb_pkg::ipsb_tx_state_t next_state;
    logic [3:0] cnt;
    logic [3:0] half_len;
    logic       sign_q;
    logic       next_sign;
    logic       take;

    assign busy = (state != ipsb_pkg::IPSB_TX_IDLE);
    assign take = start && !busy;
    assign next_sign = take ? sign : sign_q;

    always_comb begin
        next_state = state;
        case (state)
            ipsb_pkg::IPSB_TX_IDLE: begin
                if (start) begin
                    next_state = ipsb_pkg::IPSB_TX_FIRST;
                end
            end
            ipsb_pkg::IPSB_TX_FIRST: begin
                if (cnt == 4'h1) begin
                    next_state = ipsb_pkg::IPSB_TX_SECOND;
                end
            end
            ipsb_pkg::IPSB_TX_SECOND: begin
                if (cnt == 4'h1) begin
                    next_state = ipsb_pkg::IPSB_TX_IDLE;
                end
            end
            default: next_state = ipsb_pkg::IPSB_TX_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state <= ipsb_pkg::IPSB_TX_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Both halves share one length, so the symbol carries no DC
    always_ff @(posedge clk) begin
        if (reset) begin
            cnt      <= 4'h0;
            half_len <= ipsb_pkg::SHORT_HALF_CYC;
            sign_q   <= 1'b0;
        end else if (take) begin
            half_len <= long_sym ? ipsb_pkg::LONG_HALF_CYC : ipsb_pkg::SHORT_HALF_CYC;
            cnt      <= long_sym ? ipsb_pkg::LONG_HALF_CYC : ipsb_pkg::SHORT_HALF_CYC;
            sign_q   <= sign;
        end else if (state == ipsb_pkg::IPSB_TX_FIRST && cnt == 4'h1) begin
            cnt <= half_len;
        end else if (cnt != 4'h0) begin
            cnt <= cnt - 4'h1;
        end
    end

    // Levels follow the next state so they leave a flop
    always_ff @(posedge clk) begin
        if (reset) begin
            out_pos <= 1'b0;
            out_neg <= 1'b0;
        end else begin
            out_pos <= (next_state == ipsb_pkg::IPSB_TX_FIRST && next_sign)
                    || (next_state == ipsb_pkg::IPSB_TX_SECOND && !next_sign);
            out_neg <= (next_state == ipsb_pkg::IPSB_TX_FIRST && !next_sign)
                    || (next_state == ipsb_pkg::IPSB_TX_SECOND && next_sign);
        end
    end

    // ======================================================================
    // Checks
    a_tx_three_levels: assert property (
        @(posedge clk) disable iff (reset) !(out_pos && out_neg))
        else $error("pulse tx drives both polarities");
    a_tx_short_plus: assert property (
        @(posedge clk) disable iff (reset)
        take && sign && !long_sym |=> out_pos ##1 out_neg ##1 (!out_pos && !out_neg))
        else $error("short plus symbol shape wrong");
    a_tx_long_minus: assert property (
        @(posedge clk) disable iff (reset)
        take && !sign && long_sym |=> out_neg [*3] ##1 out_pos [*3] ##1 !out_pos)
        else $error("long minus symbol shape wrong");
    a_tx_long_plus: assert property (
        @(posedge clk) disable iff (reset)
        take && sign && long_sym |=> out_pos [*3] ##1 out_neg [*3] ##1 !out_neg)
        else $error("long plus half length wrong");
endmodule
